/* logic/simd_datapath.v */
// dual-lane computation datapath with banked registers and a core timer
// assumes a sequencer that holds an instruction until issue_ready
`timescale 1ns/100ps
`include "simd_dp_map.vh"

module simd_datapath (
  input  wire                core_clk,
  input  wire                rst_n,
  input  wire                issue_valid,
  output wire                issue_ready,
  input  wire [3:0]          op,
  input  wire [1:0]          fmt,
  input  wire                y_only,
  input  wire                mf_en,
  input  wire [3:0]          dst,
  input  wire [3:0]          src_a,
  input  wire [3:0]          src_b,
  input  wire [3:0]          mdst,
  input  wire [3:0]          msrc_a,
  input  wire [3:0]          msrc_b,
  input  wire [1:0]          ag_idx,
  input  wire                mode_wr,
  input  wire [`MODE_W-1:0]  mode_wdata,
  output reg  [`MODE_W-1:0]  mode_r,
  input  wire                ag_wr,
  input  wire [1:0]          ag_sel,
  input  wire [`AG_W-1:0]    ag_wdata,
  output reg  [`AG_W-1:0]    mem_addr_r,
  output reg                 mem_rd_r,
  output reg                 mem_wr_r,
  input  wire [`DW-1:0]      mem_rdata_x,
  input  wire [`DW-1:0]      mem_rdata_y,
  output reg  [`DW-1:0]      mem_wdata_x_r,
  output reg  [`DW-1:0]      mem_wdata_y_r,
  input  wire                tmr_en,
  input  wire [31:0]         tmr_period,
  output reg                 tmr_tick_r
);

  // extended float: sign 39, exponent 38:31, mantissa 30:0; single uses 39:8
  function [`DW-1:0] fmul;
    input [`DW-1:0] a;
    input [`DW-1:0] b;
    reg   [63:0]    p;
    reg   [9:0]     e;
    reg   [30:0]    m;
    begin
      p = {1'b1, a[30:0]} * {1'b1, b[30:0]};
      e = {2'b00, a[38:31]} + {2'b00, b[38:31]} - `FP_BIAS;
      if (p[63])
      begin
        m = p[62:32];
        e = e + 10'h001;
      end
      else
        m = p[61:31];
      if (a[38:31] == 8'h00 || b[38:31] == 8'h00 || e[9])
        fmul = {a[39] ^ b[39], 39'h0};
      else if (e[8])
        fmul = {a[39] ^ b[39], 8'hFF, 31'h0};
      else
        fmul = {a[39] ^ b[39], e[7:0], m};
    end
  endfunction

  // multiplier unit
  function [`DW-1:0] mul_unit;
    input [1:0]     f;
    input [`DW-1:0] a;
    input [`DW-1:0] b;
    reg   [63:0]    p;
    begin
      p = a[31:0] * b[31:0];
      if (f == `FMT_FIX)
        mul_unit = {8'h00, p[31:0]};
      else if (f == `FMT_SGL)
        mul_unit = fmul(a, b) & {32'hFFFFFFFF, 8'h00};
      else
        mul_unit = fmul(a, b);
    end
  endfunction

  // ALU and shifter unit
  function [`DW-1:0] alu_unit;
    input [3:0]     o;
    input [`DW-1:0] a;
    input [`DW-1:0] b;
    input [`DW-1:0] mr;
    reg   [31:0]    s;
    begin
      s = $signed(a[31:0]) >>> b[4:0];
      case (o)
        `OP_ADD:  alu_unit = {8'h00, a[31:0] + b[31:0]};
        `OP_SUB:  alu_unit = {8'h00, a[31:0] - b[31:0]};
        `OP_AND:  alu_unit = a & b;
        `OP_OR:   alu_unit = a | b;
        `OP_XOR:  alu_unit = a ^ b;
        `OP_SHL:  alu_unit = {8'h00, a[31:0] << b[4:0]};
        `OP_SHR:  alu_unit = {8'h00, s};
        `OP_FNEG: alu_unit = {~a[39], a[38:0]};
        `OP_FABS: alu_unit = {1'b0, a[38:0]};
        `OP_MRD:  alu_unit = mr;
        default:  alu_unit = a;
      endcase
    end
  endfunction

  // operand select: 1 = last main result, 2 = last multiplier result
  function [`DW-1:0] opnd;
    input [1:0]     f;
    input [`DW-1:0] rf;
    input [`DW-1:0] wa;
    input [`DW-1:0] wm;
    input           lv;
    begin
      if (f == 2'h1 && lv)
        opnd = wa;
      else if (f == 2'h2 && lv)
        opnd = wm;
      else
        opnd = rf;
    end
  endfunction

  function [1:0] fwd;
    input [`RF_AW-1:0] ra;
    input              va;
    input [`RF_AW-1:0] da;
    input              vm;
    input [`RF_AW-1:0] dm;
    begin
      if (vm && ra == dm)
        fwd = 2'h2;
      else if (va && ra == da)
        fwd = 2'h1;
      else
        fwd = 2'h0;
    end
  endfunction

  reg                ex_v_r;
  reg  [2:0]         ex_wait_r;
  reg  [3:0]         ex_op_r;
  reg  [1:0]         ex_fmt_r;
  reg                ex_mf_r;
  reg                ex_xact_r;
  reg                ex_yact_r;
  reg                ex_mrb_r;
  reg  [`RF_AW-1:0]  ex_dst_r;
  reg  [`RF_AW-1:0]  ex_mdst_r;
  reg  [7:0]         ex_fw_r;
  reg                wb_xv_r;
  reg                wb_yv_r;
  reg  [`DW-1:0]     wb_ax_r;
  reg  [`DW-1:0]     wb_ay_r;
  reg  [`DW-1:0]     wb_mx_r;
  reg  [`DW-1:0]     wb_my_r;
  reg  [`DW-1:0]     mr_x_r [0:1];
  reg  [`DW-1:0]     mr_y_r [0:1];
  reg  [`AG_W-1:0]   ag_r [0:7];
  reg  [31:0]        tmr_cnt_r;
  reg  [2:0]         lat_nxt;
  reg                dep;
  integer            i;

  wire [`DW-1:0] rx_a, rx_b, rx_c, rx_d;
  wire [`DW-1:0] ry_a, ry_b, ry_c, ry_d;

  wire done = ex_v_r && ex_wait_r == 3'h0;
  assign issue_ready = !ex_v_r || ex_wait_r == 3'h0;
  wire go = issue_valid && issue_ready;
  wire bk = mode_r[`MODE_ALT_DREG];
  wire [`RF_AW-1:0] ra_a = {bk, src_a};
  wire [`RF_AW-1:0] ra_b = {bk, src_b};
  wire [`RF_AW-1:0] ra_c = {bk, msrc_a};
  wire [`RF_AW-1:0] ra_d = {bk, msrc_b};
  wire [2:0] agi = {mode_r[`MODE_ALT_AG], ag_idx};
  wire is_mem = op == `OP_LOAD || op == `OP_STORE;

  // destinations of the instruction retiring now, for dependency and forwarding
  wire ret_a = done && ex_op_r != `OP_MAC && ex_op_r != `OP_STORE;
  wire ret_m = done && ex_mf_r;

  // both lanes share one forwarding decode, each reading its own register file and retired results
  wire [`DW-1:0] ax = opnd(ex_fw_r[1:0], rx_a, wb_ax_r, wb_mx_r, wb_xv_r);
  wire [`DW-1:0] bx = opnd(ex_fw_r[3:2], rx_b, wb_ax_r, wb_mx_r, wb_xv_r);
  wire [`DW-1:0] cx = opnd(ex_fw_r[5:4], rx_c, wb_ax_r, wb_mx_r, wb_xv_r);
  wire [`DW-1:0] dx = opnd(ex_fw_r[7:6], rx_d, wb_ax_r, wb_mx_r, wb_xv_r);
  wire [`DW-1:0] ay = opnd(ex_fw_r[1:0], ry_a, wb_ay_r, wb_my_r, wb_yv_r);
  wire [`DW-1:0] by = opnd(ex_fw_r[3:2], ry_b, wb_ay_r, wb_my_r, wb_yv_r);
  wire [`DW-1:0] cy = opnd(ex_fw_r[5:4], ry_c, wb_ay_r, wb_my_r, wb_yv_r);
  wire [`DW-1:0] dy = opnd(ex_fw_r[7:6], ry_d, wb_ay_r, wb_my_r, wb_yv_r);

  // three units evaluate in parallel every cycle
  wire [`DW-1:0] alu_x = alu_unit(ex_op_r, ax, bx, mr_x_r[ex_mrb_r]);
  wire [`DW-1:0] alu_y = alu_unit(ex_op_r, ay, by, mr_y_r[ex_mrb_r]);
  wire [`DW-1:0] mpy_x = mul_unit(ex_fmt_r, ax, bx);
  wire [`DW-1:0] mpy_y = mul_unit(ex_fmt_r, ay, by);
  wire [`DW-1:0] mfx = mul_unit(ex_fmt_r, cx, dx);
  wire [`DW-1:0] mfy = mul_unit(ex_fmt_r, cy, dy);
  wire main_mul = ex_op_r == `OP_MUL || ex_op_r == `OP_FMUL;
  wire [`DW-1:0] res_x = ex_op_r == `OP_LOAD ? mem_rdata_x :
                         (main_mul ? mpy_x : alu_x);
  wire [`DW-1:0] res_y = ex_op_r == `OP_LOAD ? mem_rdata_y :
                         (main_mul ? mpy_y : alu_y);

  wire wx_a = ret_a && ex_xact_r;
  wire wy_a = ret_a && ex_yact_r;

  lane_regfile u_rf_x (
    .core_clk (core_clk),
    .rd_en    (go),
    .ra_a     (ra_a),
    .ra_b     (ra_b),
    .ra_c     (ra_c),
    .ra_d     (ra_d),
    .rd_a     (rx_a),
    .rd_b     (rx_b),
    .rd_c     (rx_c),
    .rd_d     (rx_d),
    .we0      (wx_a),
    .wa0      (ex_dst_r),
    .wd0      (res_x),
    .we1      (ret_m && ex_xact_r),
    .wa1      (ex_mdst_r),
    .wd1      (mfx)
  );

  lane_regfile u_rf_y (
    .core_clk (core_clk),
    .rd_en    (go),
    .ra_a     (ra_a),
    .ra_b     (ra_b),
    .ra_c     (ra_c),
    .ra_d     (ra_d),
    .rd_a     (ry_a),
    .rd_b     (ry_b),
    .rd_c     (ry_c),
    .rd_d     (ry_d),
    .we0      (wy_a),
    .wa0      (ex_dst_r),
    .wd0      (res_y),
    .we1      (ret_m && ex_yact_r),
    .wa1      (ex_mdst_r),
    .wd1      (mfy)
  );

  // issue latency: one, two on a floating dependency, per-op for double
  always @*
  begin
    dep = (ret_a && (ra_a == ex_dst_r || ra_b == ex_dst_r ||
           ra_c == ex_dst_r || ra_d == ex_dst_r)) ||
          (ret_m && (ra_a == ex_mdst_r || ra_b == ex_mdst_r ||
           ra_c == ex_mdst_r || ra_d == ex_mdst_r));
    if (fmt == `FMT_DBL && !is_mem)
    begin
      if (op == `OP_MUL || op == `OP_FMUL || op == `OP_MAC)
        lat_nxt = `LAT_DBL_MUL;
      else if (op == `OP_ADD || op == `OP_SUB)
        lat_nxt = `LAT_DBL_ADD;
      else
        lat_nxt = `LAT_DBL_MIN;
    end
    else if (fmt != `FMT_FIX && dep && !is_mem)
      lat_nxt = `LAT_FP_DEP;
    else
      lat_nxt = `LAT_ONE;
  end

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ex_v_r    <= 1'b0;
      ex_wait_r <= 3'h0;
      ex_op_r   <= `OP_PASS;
      ex_fmt_r  <= `FMT_FIX;
      ex_mf_r   <= 1'b0;
      ex_xact_r <= 1'b0;
      ex_yact_r <= 1'b0;
      ex_mrb_r  <= 1'b0;
      ex_dst_r  <= 5'h00;
      ex_mdst_r <= 5'h00;
      ex_fw_r   <= 8'h00;
    end
    else if (go)
    begin
      ex_v_r    <= 1'b1;
      ex_wait_r <= lat_nxt - 3'h1;
      ex_op_r   <= op;
      ex_fmt_r  <= fmt;
      ex_mf_r   <= mf_en && !is_mem;
      ex_xact_r <= !y_only;
      ex_yact_r <= mode_r[`MODE_Y_EN] || y_only;
      ex_mrb_r  <= mode_r[`MODE_ALT_MR];
      ex_dst_r  <= {bk, dst};
      ex_mdst_r <= {bk, mdst};
      ex_fw_r   <= {fwd(ra_d, ret_a, ex_dst_r, ret_m, ex_mdst_r),
                    fwd(ra_c, ret_a, ex_dst_r, ret_m, ex_mdst_r),
                    fwd(ra_b, ret_a, ex_dst_r, ret_m, ex_mdst_r),
                    fwd(ra_a, ret_a, ex_dst_r, ret_m, ex_mdst_r)};
    end
    else if (done)
      ex_v_r <= 1'b0;
    else if (ex_v_r)
      ex_wait_r <= ex_wait_r - 3'h1;
  end

  // retired results kept for forwarding until the next retirement
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wb_xv_r <= 1'b0;
      wb_yv_r <= 1'b0;
      wb_ax_r <= 40'h0;
      wb_ay_r <= 40'h0;
      wb_mx_r <= 40'h0;
      wb_my_r <= 40'h0;
    end
    else if (done)
    begin
      wb_xv_r <= ex_xact_r;
      wb_yv_r <= ex_yact_r;
      wb_ax_r <= res_x;
      wb_ay_r <= res_y;
      wb_mx_r <= mfx;
      wb_my_r <= mfy;
    end
  end

  // mode, multiplier result banks, address generators, memory side
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_r        <= `MODE_RST;
      mem_addr_r    <= 16'h0000;
      mem_rd_r      <= 1'b0;
      mem_wr_r      <= 1'b0;
      mem_wdata_x_r <= 40'h0;
      mem_wdata_y_r <= 40'h0;
      for (i = 0; i < 2; i = i + 1)
      begin
        mr_x_r[i] <= 40'h0;
        mr_y_r[i] <= 40'h0;
      end
      for (i = 0; i < 8; i = i + 1)
        ag_r[i] <= 16'h0000;
    end
    else
    begin
      if (mode_wr)
        mode_r <= mode_wdata;
      if (done && ex_op_r == `OP_MAC)
      begin
        if (ex_xact_r)
          mr_x_r[ex_mrb_r] <= mr_x_r[ex_mrb_r] + mpy_x;
        if (ex_yact_r)
          mr_y_r[ex_mrb_r] <= mr_y_r[ex_mrb_r] + mpy_y;
      end
      mem_rd_r <= go && op == `OP_LOAD;
      mem_wr_r <= 1'b0;
      if (go && is_mem)
      begin
        mem_addr_r <= ag_r[agi];
        ag_r[agi]  <= ag_r[agi] + `AG_STEP;
      end
      if (ag_wr)
        ag_r[{mode_r[`MODE_ALT_AG], ag_sel}] <= ag_wdata;
      if (go && op == `OP_STORE)
        mem_wr_r <= 1'b1;
      if (done && ex_op_r == `OP_STORE)
      begin
        mem_wdata_x_r <= ax;
        mem_wdata_y_r <= ay;
      end
    end
  end

  // core timer on the core clock
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tmr_cnt_r  <= 32'h0;
      tmr_tick_r <= 1'b0;
    end
    else if (!tmr_en)
    begin
      tmr_cnt_r  <= 32'h0;
      tmr_tick_r <= 1'b0;
    end
    else if ({1'b0, tmr_cnt_r} + 33'h1 >= {1'b0, tmr_period})
    begin
      tmr_cnt_r  <= 32'h0;
      tmr_tick_r <= 1'b1;
    end
    else
    begin
      tmr_cnt_r  <= tmr_cnt_r + 32'h1;
      tmr_tick_r <= 1'b0;
    end
  end

endmodule // simd_datapath

/* logic/simd_dp_map.vh */
// constants of the dual-lane datapath: opcodes, formats, mode bits, latencies
// included by the datapath and its register file
`ifndef SIMD_DP_MAP_VH
`define SIMD_DP_MAP_VH

`define DW            40
`define RF_AW         5
`define AG_W          16

`define OP_PASS       4'h0
`define OP_ADD        4'h1
`define OP_SUB        4'h2
`define OP_AND        4'h3
`define OP_OR         4'h4
`define OP_XOR        4'h5
`define OP_SHL        4'h6
`define OP_SHR        4'h7
`define OP_MUL        4'h8
`define OP_MAC        4'h9
`define OP_FNEG       4'hA
`define OP_FABS       4'hB
`define OP_FMUL       4'hC
`define OP_MRD        4'hD
`define OP_LOAD       4'hE
`define OP_STORE      4'hF

`define FMT_FIX       2'h0
`define FMT_SGL       2'h1
`define FMT_EXT       2'h2
`define FMT_DBL       2'h3

`define MODE_W        4
`define MODE_Y_EN     0
`define MODE_ALT_DREG 1
`define MODE_ALT_AG   2
`define MODE_ALT_MR   3
`define MODE_RST      4'h0

`define FP_BIAS       10'h07F
`define LAT_ONE       3'h1
`define LAT_FP_DEP    3'h2
`define LAT_DBL_MIN   3'h2
`define LAT_DBL_ADD   3'h3
`define LAT_DBL_MUL   3'h6
`define AG_STEP       16'h0001

`endif

/* logic/lane_regfile.v */
// one lane's data register file: 16 primary plus 16 alternate entries
// four registered read ports, two write ports; port 1 wins on a clash
`timescale 1ns/100ps
`include "simd_dp_map.vh"

module lane_regfile (
  input  wire                core_clk,
  input  wire                rd_en,
  input  wire [`RF_AW-1:0]   ra_a,
  input  wire [`RF_AW-1:0]   ra_b,
  input  wire [`RF_AW-1:0]   ra_c,
  input  wire [`RF_AW-1:0]   ra_d,
  output reg  [`DW-1:0]      rd_a,
  output reg  [`DW-1:0]      rd_b,
  output reg  [`DW-1:0]      rd_c,
  output reg  [`DW-1:0]      rd_d,
  input  wire                we0,
  input  wire [`RF_AW-1:0]   wa0,
  input  wire [`DW-1:0]      wd0,
  input  wire                we1,
  input  wire [`RF_AW-1:0]   wa1,
  input  wire [`DW-1:0]      wd1
);

  reg [`DW-1:0] mem [0:31];

  // inactive bank is never touched, so its contents survive a switch
  always @(posedge core_clk)
  begin
    if (we0)
      mem[wa0] <= wd0;
    if (we1)
      mem[wa1] <= wd1;
    if (rd_en)
    begin
      rd_a <= mem[ra_a];
      rd_b <= mem[ra_b];
      rd_c <= mem[ra_c];
      rd_d <= mem[ra_d];
    end
  end

endmodule // lane_regfile

/* verification/l1_mem_model.sv */
// both data buses of the l1 memory as seen by the datapath's load port
// answers within the read strobe cycle; otherwise shows a changing pattern
`timescale 1ns/100ps

module l1_mem_model (
  input  wire         core_clk,
  input  wire         mem_rd_r,
  input  wire [15:0]  mem_addr_r,
  output wire [39:0]  mem_rdata_x,
  output wire [39:0]  mem_rdata_y
);
  reg [39:0] junk_r = 40'h5A5A5A5A5A;

  // no stale data outside a read
  always @(posedge core_clk)
    junk_r <= ~junk_r;

  assign mem_rdata_x = mem_rd_r ? {24'h000000, mem_addr_r} + 40'h0000000003 : junk_r;
  assign mem_rdata_y = mem_rd_r ? {24'h000000, mem_addr_r} + 40'h0000000007 : ~junk_r;
endmodule // l1_mem_model

/* verification/simd_dp_monitor.sv */
// checker of issue timing, memory strobes, mode writes and timer ticks
// bound to simd_datapath; sees its ports only
`timescale 1ns/100ps
`include "simd_dp_map.vh"

module simd_dp_monitor (
  input wire                core_clk,
  input wire                rst_n,
  input wire                issue_valid,
  input wire                issue_ready,
  input wire [3:0]          op,
  input wire [1:0]          fmt,
  input wire                mode_wr,
  input wire [`MODE_W-1:0]  mode_wdata,
  input wire [`MODE_W-1:0]  mode_r,
  input wire [`AG_W-1:0]    mem_addr_r,
  input wire                mem_rd_r,
  input wire                mem_wr_r,
  input wire                tmr_en,
  input wire [31:0]         tmr_period,
  input wire                tmr_tick_r
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire take    = issue_valid && issue_ready;
  wire take_ld = take && op == `OP_LOAD;
  wire take_st = take && op == `OP_STORE;
  wire dbl     = take && fmt == `FMT_DBL;

  sequence s_stall2; !issue_ready [*2] ##1 issue_ready; endsequence
  sequence s_stall5; !issue_ready [*5] ##1 issue_ready; endsequence

  property p_rst_primary; $rose(rst_n) |-> mode_r == `MODE_RST && issue_ready; endproperty
  property p_mode_wr; mode_wr |=> mode_r == $past(mode_wdata); endproperty
  property p_ld_strobe; take_ld |=> mem_rd_r; endproperty
  property p_rd_cause; mem_rd_r |-> $past(take_ld); endproperty
  property p_st_strobe; take_st |=> mem_wr_r; endproperty
  property p_wr_cause; mem_wr_r |-> $past(take_st); endproperty
  property p_dbl_mul;
    dbl && (op == `OP_MUL || op == `OP_FMUL || op == `OP_MAC) |=> s_stall5;
  endproperty
  property p_dbl_add; dbl && (op == `OP_ADD || op == `OP_SUB) |=> s_stall2; endproperty
  property p_fix_one; take && fmt == `FMT_FIX |=> issue_ready; endproperty
  property p_addr_hold; !mem_rd_r && !mem_wr_r |-> $stable(mem_addr_r); endproperty
  property p_tick_pulse; tmr_tick_r && tmr_period > 32'h1 |=> !tmr_tick_r; endproperty
  property p_tick_en; tmr_tick_r |-> $past(tmr_en); endproperty

  a_rst_primary: assert property (p_rst_primary) else $error("banks not primary");
  a_mode_wr: assert property (p_mode_wr) else $error("mode write lost");
  a_ld_strobe: assert property (p_ld_strobe) else $error("load strobe missing");
  a_rd_cause: assert property (p_rd_cause) else $error("stray read strobe");
  a_st_strobe: assert property (p_st_strobe) else $error("store strobe missing");
  a_wr_cause: assert property (p_wr_cause) else $error("stray write strobe");
  a_dbl_mul: assert property (p_dbl_mul) else $error("double mul stall");
  a_dbl_add: assert property (p_dbl_add) else $error("double add stall");
  a_fix_one: assert property (p_fix_one) else $error("fixed op stalled");
  a_addr_hold: assert property (p_addr_hold) else $error("address moved");
  a_tick_pulse: assert property (p_tick_pulse) else $error("tick too long");
  a_tick_en: assert property (p_tick_en) else $error("tick while off");
endmodule // simd_dp_monitor

bind simd_datapath simd_dp_monitor u_mon (
  .core_clk, .rst_n, .issue_valid, .issue_ready, .op, .fmt, .mode_wr, .mode_wdata,
  .mode_r, .mem_addr_r, .mem_rd_r, .mem_wr_r, .tmr_en, .tmr_period, .tmr_tick_r
);

/* verification/tb_top.sv */
// self-checking bench for the dual-lane datapath
// inputs change at falling edges; l1_mem_model answers loads
`timescale 1ns/100ps
`include "simd_dp_map.vh"
`define CHK(nm, e, g) begin cmp_count = cmp_count + 1; if ((g) !== (e)) begin \
  n_mismatch = n_mismatch + 1; $display("BAD %s exp %0h got %0h", nm, e, g); end end

module tb_top;
  reg         core_clk = 1'b0;
  reg         rst_n = 1'b0;
  reg         issue_valid = 1'b0, y_only = 1'b0, mf_en = 1'b0;
  reg  [3:0]  op = 4'h0, dst = 4'h0, src_a = 4'h0, src_b = 4'h0;
  reg  [3:0]  mdst = 4'h0, msrc_a = 4'h0, msrc_b = 4'h0, mode_wdata = 4'h0;
  reg  [1:0]  fmt = 2'h0, ag_idx = 2'h0, ag_sel = 2'h0;
  reg         mode_wr = 1'b0, ag_wr = 1'b0, tmr_en = 1'b0;
  reg  [15:0] ag_wdata = 16'h0000;
  reg  [31:0] tmr_period = 32'h00000000;
  wire        issue_ready, mem_rd_r, mem_wr_r, tmr_tick_r;
  wire [3:0]  mode_r;
  wire [15:0] mem_addr_r;
  wire [39:0] mem_rdata_x, mem_rdata_y, mem_wdata_x_r, mem_wdata_y_r;
  integer     n_mismatch = 0, cmp_count = 0, w, i, n;
  reg  [8:0]  e;
  localparam [89:0] LAT_TAB = {
    `OP_PASS, `FMT_FIX, 3'h0, `OP_PASS, `FMT_SGL, 3'h0, `OP_PASS, `FMT_EXT, 3'h0,
    `OP_FMUL, `FMT_SGL, 3'h0, `OP_AND, `FMT_DBL, 3'h1, `OP_ADD, `FMT_DBL, 3'h2,
    `OP_SUB, `FMT_DBL, 3'h2, `OP_MUL, `FMT_DBL, 3'h5, `OP_FMUL, `FMT_DBL, 3'h5,
    `OP_MAC, `FMT_DBL, 3'h5};

  always #20 core_clk = ~core_clk;

  simd_datapath u_dut (.core_clk, .rst_n, .issue_valid, .issue_ready, .op, .fmt, .y_only,
    .mf_en, .dst, .src_a, .src_b, .mdst, .msrc_a, .msrc_b, .ag_idx, .mode_wr, .mode_wdata,
    .mode_r, .ag_wr, .ag_sel, .ag_wdata, .mem_addr_r, .mem_rd_r, .mem_wr_r, .mem_rdata_x,
    .mem_rdata_y, .mem_wdata_x_r, .mem_wdata_y_r, .tmr_en, .tmr_period, .tmr_tick_r);
  l1_mem_model u_mem (.core_clk, .mem_rd_r, .mem_addr_r, .mem_rdata_x, .mem_rdata_y);

  // valid stays up on return so back-to-back issue needs no gap
  task automatic issue(input [3:0] o, input [1:0] f, input yo, input [3:0] d,
                       input [3:0] a, input [3:0] b);
    begin
      op = o; fmt = f; y_only = yo; dst = d; src_a = a; src_b = b;
      issue_valid = 1'b1;
      w = 0;
      while (issue_ready !== 1'b1 && w < 20)
      begin
        @(negedge core_clk);
        w = w + 1;
      end
      @(negedge core_clk);
    end
  endtask

  task automatic setm(input [3:0] v);
    begin
      issue_valid = 1'b0; mode_wr = 1'b1; mode_wdata = v;
      @(negedge core_clk);
      mode_wr = 1'b0;
      `CHK("mode", v, mode_r)
    end
  endtask

  task automatic ld(input [3:0] d, input [15:0] adr);
    begin
      ag_idx = 2'h0;
      issue(`OP_LOAD, `FMT_FIX, 1'b0, d, 4'h0, 4'h0);
      `CHK("rd strobe", 1'b1, mem_rd_r)
      `CHK("ld addr", adr, mem_addr_r)
    end
  endtask

  task automatic st(input [3:0] s, input [39:0] ex, input [39:0] ey);
    begin
      ag_idx = 2'h1;
      issue(`OP_STORE, `FMT_FIX, 1'b0, 4'h0, s, 4'h0);
      `CHK("st wait", 0, w)
      `CHK("wr strobe", 1'b1, mem_wr_r)
      issue_valid = 1'b0;
      @(negedge core_clk);
      `CHK("x data", ex, mem_wdata_x_r)
      `CHK("y data", ey, mem_wdata_y_r)
    end
  endtask

  task automatic t_simd;
    begin
      `CHK("reset mode", 4'h0, mode_r)
      ag_wr = 1'b1; ag_sel = 2'h0; ag_wdata = 16'h0010;
      @(negedge core_clk);
      ag_wr = 1'b0;
      setm(4'h1);
      ld(4'h1, 16'h0010);
      ld(4'h2, 16'h0011);
      issue(`OP_ADD, `FMT_FIX, 1'b0, 4'h3, 4'h1, 4'h2);
      `CHK("fwd wait", 0, w)
      st(4'h3, 32'h27, 32'h2F);
      ld(4'h4, 16'h0012);
      ld(4'h5, 16'h0013);
      issue(`OP_ADD, `FMT_FIX, 1'b1, 4'h4, 4'h1, 4'h2);
      setm(4'h0);
      issue(`OP_ADD, `FMT_FIX, 1'b0, 4'h5, 4'h1, 4'h2);
      setm(4'h1);
      st(4'h4, 32'h15, 32'h2F);
      st(4'h5, 32'h27, 32'h1A);
      mf_en = 1'b1; mdst = 4'h7; msrc_a = 4'h1; msrc_b = 4'h2;
      issue(`OP_ADD, `FMT_FIX, 1'b0, 4'h6, 4'h1, 4'h2);
      mf_en = 1'b0;
      st(4'h6, 32'h27, 32'h2F);
      st(4'h7, 32'h17C, 32'h228);
      $display("test simd done");
    end
  endtask

  task automatic t_lat;
    begin
      for (i = 0; i < 10; i = i + 1)
      begin
        e = LAT_TAB[i*9 +: 9];
        issue(e[8:5], e[4:3], 1'b0, 4'hA, 4'h1, 4'h2);
        issue(`OP_PASS, `FMT_FIX, 1'b0, 4'h9, 4'h1, 4'h1);
        `CHK("stall", e[2:0], w)
      end
      issue(`OP_FMUL, `FMT_SGL, 1'b0, 4'h8, 4'h1, 4'h2);
      issue(`OP_FMUL, `FMT_SGL, 1'b0, 4'h9, 4'h8, 4'h2);
      `CHK("dep take", 0, w)
      issue(`OP_PASS, `FMT_FIX, 1'b0, 4'hA, 4'h1, 4'h1);
      `CHK("dep stall", 1, w)
      $display("test latency done");
    end
  endtask

  task automatic t_bank;
    begin
      setm(4'h7);
      ag_wr = 1'b1; ag_sel = 2'h0; ag_wdata = 16'h0040;
      @(negedge core_clk);
      ag_wr = 1'b0;
      ld(4'h1, 16'h0040);
      st(4'h1, 32'h43, 32'h47);
      setm(4'h1);
      st(4'h1, 32'h13, 32'h17);
      ld(4'hF, 16'h0014);
      setm(4'h7);
      st(4'h1, 32'h43, 32'h47);
      $display("test bank done");
    end
  endtask

  // shifter, multiplier result banks, extended sign, then a reset in mid-run
  task automatic t_unit;
    begin
      setm(4'h1);
      issue(`OP_SHL, `FMT_FIX, 1'b0, 4'h8, 4'h1, 4'h2);
      st(4'h8, 40'h0001300000, 40'h0017000000);
      issue(`OP_SHR, `FMT_FIX, 1'b0, 4'h9, 4'h8, 4'h2);
      st(4'h9, 40'h0000000013, 40'h0000000017);
      issue(`OP_MAC, `FMT_FIX, 1'b0, 4'h0, 4'h1, 4'h2);
      issue(`OP_MRD, `FMT_FIX, 1'b0, 4'h9, 4'h0, 4'h0);
      setm(4'h9);
      issue(`OP_MAC, `FMT_FIX, 1'b0, 4'h0, 4'h1, 4'h1);
      issue(`OP_MRD, `FMT_FIX, 1'b0, 4'hA, 4'h0, 4'h0);
      setm(4'h1);
      issue(`OP_MRD, `FMT_FIX, 1'b0, 4'hB, 4'h0, 4'h0);
      issue(`OP_FNEG, `FMT_EXT, 1'b0, 4'hC, 4'h1, 4'h0);
      st(4'h9, 40'h000000017C, 40'h0000000228);
      st(4'hA, 40'h0000000169, 40'h0000000211);
      st(4'hB, 40'h000000017C, 40'h0000000228);
      st(4'hC, 40'h8000000013, 40'h8000000017);
      setm(4'hE);
      rst_n = 1'b0;
      repeat (3) @(negedge core_clk);
      rst_n = 1'b1;
      @(negedge core_clk);
      `CHK("rst mode", 4'h0, mode_r)
      `CHK("rst ready", 1'b1, issue_ready)
      $display("test units done");
    end
  endtask

  task automatic t_timer;
    begin
      tmr_period = 32'h5; tmr_en = 1'b1; w = 0; n = 0;
      while (tmr_tick_r !== 1'b1 && w < 20)
      begin
        @(negedge core_clk);
        w = w + 1;
      end
      for (i = 0; i < 20; i = i + 1)
      begin
        @(negedge core_clk);
        if (tmr_tick_r === 1'b1) n = n + 1;
      end
      `CHK("ticks", 4, n)
      tmr_en = 1'b0; n = 0;
      for (i = 0; i < 12; i = i + 1)
      begin
        @(negedge core_clk);
        if (tmr_tick_r !== 1'b0) n = n + 1;
      end
      `CHK("ticks off", 0, n)
      $display("test timer done");
    end
  endtask

  task automatic complete_run;
    begin
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask

  initial
  begin
    #(40 * 3000);
    n_mismatch = n_mismatch + 1;
    complete_run;
  end

  initial
  begin
    repeat (20) @(negedge core_clk);
    rst_n = 1'b1;
    t_simd;
    t_lat;
    t_bank;
    t_unit;
    t_timer;
    complete_run;
  end
endmodule // tb_top
